//--- pfm_pkg.sv
package pfm_pkg;

  localparam int NUM_PADS = 45;
  localparam int NUM_SLOTS = 48;
  localparam int NUM_FUNCS = 8;
  localparam int SEL_WORDS = 6;

  // APB map: six selection words, eight lines per word, then a status word.
  localparam logic [7:0] ADDR_FUNC_SEL0 = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [31:0] FUNC_SEL_RESET = 32'h00000000;

  // Selection nibble: bit 3 hands the line to a peripheral, bits 2:0 pick A to H.
  localparam int SEL_EN_BIT = 3;

  // Lines 23 to 31 are not bonded out.
  localparam logic [NUM_PADS-1:0] PAD_EXISTS = 45'h1FFF_007F_FFFF;

  localparam logic [5:0] PAD_JTAG_TCK = 6'h00;
  localparam logic [5:0] PAD_JTAG_TMS = 6'h01;
  localparam logic [5:0] PAD_JTAG_TDO = 6'h02;
  localparam logic [5:0] PAD_JTAG_TDI = 6'h03;
  localparam logic [5:0] PAD_LINK_DATA_OUT = 6'h00;
  localparam logic [5:0] PAD_WAKE = 6'h0B;
  localparam logic [5:0] PAD_XIN0 = 6'h08;
  localparam logic [5:0] PAD_XOUT0 = 6'h09;
  localparam logic [5:0] PAD_XIN32 = 6'h0A;
  localparam logic [5:0] PAD_XOUT32 = 6'h0C;
  localparam logic [5:0] PAD_XIN32_ALT = 6'h0D;
  localparam logic [5:0] PAD_XOUT32_ALT = 6'h14;

  // Trace output pads, indexed by the bit position in pfm_trace_s.
  localparam logic [9:0][5:0] TRACE_PAD_MAP1 = {6'h04, 6'h06, 6'h07, 6'h0B, 6'h0A,
                                                6'h12, 6'h11, 6'h10, 6'h0F, 6'h0E};
  localparam logic [9:0][5:0] TRACE_PAD_MAP0 = {6'h04, 6'h21, 6'h2B, 6'h2C, 6'h20,
                                                6'h24, 6'h25, 6'h23, 6'h22, 6'h29};
  localparam logic [5:0] EVT_IN_PAD_MAP1 = 6'h05;
  localparam logic [5:0] EVT_IN_PAD_MAP0 = 6'h28;

  // Selections (bit n = selection n) that open the two-wire pad features per line.
  localparam logic [NUM_PADS-1:0][7:0] TWI_FEAT_MASK = '{
    6'h05: 8'h42, 6'h07: 8'h0C, 6'h11: 8'h08, 6'h15: 8'h22,
    6'h24: 8'h68, 6'h25: 8'h28, default: 8'h00};

  typedef struct packed {
    logic [NUM_PADS-1:0] out;
    logic [NUM_PADS-1:0] oe;
  } pfm_drive_s;

  typedef struct packed {
    logic debug_event_out_n;
    logic trace_clock_out;
    logic [1:0] trace_frame_control;
    logic [5:0] trace_data_out;
  } pfm_trace_s;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } pfm_jtag_in_s;

endpackage

//--- pfm_pad_mux.sv
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Each line is plain GPIO or peripheral selection A to H from registers.
// - Priority ascending: mux, trace, link data out, boundary scan, oscillators.
// - Two-wire, 5V and SMBus features only with two-wire or PWM open-drain selected.
// - Boundary-scan enabled puts TCK, TMS, TDO, TDI on lines 0 to 3.
// - Trace enabled hands the trace pins to the trace system.
// - Trace map select moves every trace pin except event-out.
// - Oscillator pins follow clock-control enables only, never the GPIO selection.
// - Single-pin debug data on the reset pin only when that interface is enabled.
// - Link data out on line 0 only when enabled and two-pin mode commanded.
// - Wake-up input on line 11 is always sampled.
module pfm_pad_mux
  import pfm_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire pfm_drive_s GPIO_DRIVE_I,
  output logic [NUM_PADS-1:0] GPIO_IN_O,
  input wire pfm_drive_s [NUM_FUNCS-1:0] PERIPH_DRIVE_I,
  output logic [NUM_FUNCS-1:0][NUM_PADS-1:0] PERIPH_IN_O,
  input wire logic [NUM_PADS-1:0] PAD_IN_I,
  output logic [NUM_PADS-1:0] PAD_OUT_O,
  output logic [NUM_PADS-1:0] PAD_OE_O,
  output logic [NUM_PADS-1:0] PAD_TWI_FEAT_EN_O,
  output logic [NUM_PADS-1:0] PAD_ANALOG_O,
  input wire logic JTAG_EN_I,
  input wire logic JTAG_TDO_I,
  output pfm_jtag_in_s JTAG_IN_O,
  input wire logic TRACE_EN_I,
  input wire logic TRACE_MAP_SELECT_I,
  input wire pfm_trace_s TRACE_I,
  output logic DEBUG_EVENT_IN_N_O,
  input wire logic SINGLE_PIN_DBG_EN_I,
  input wire logic TWO_PIN_MODE_I,
  input wire logic DEBUG_LINK_DATA_OUTPUT_I,
  input wire logic DBG_DATA_OUT_I,
  input wire logic DBG_DATA_OE_I,
  output logic DBG_DATA_IN_O,
  input wire logic RST_PAD_IN_I,
  output logic RST_PAD_OUT_O,
  output logic RST_PAD_OE_O,
  input wire logic OSC0_EN_I,
  input wire logic OSC32_EN_I,
  input wire logic OSC32_ALT_I,
  output logic WAKE_N_O
);

  logic rst_meta_n;
  logic rst_n;
  logic next_rst_meta_n;
  logic next_rst_n;
  logic [3:0] func_sel [NUM_SLOTS];
  logic [3:0] next_func_sel [NUM_SLOTS];
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [7:0] status;
  pfm_drive_s next_pad;
  logic [NUM_PADS-1:0] next_twi;
  logic [NUM_PADS-1:0] next_analog;
  logic [NUM_PADS-1:0] mux_owned;
  logic [NUM_FUNCS-1:0][NUM_PADS-1:0] next_periph_in;
  pfm_jtag_in_s next_jtag;
  logic next_evt_in_n;
  logic next_dbg_in;
  logic next_rst_out;
  logic next_rst_oe;
  logic [5:0] evt_pad;
  logic [5:0] tpad;
  logic [2:0] sel;
  logic setup;
  logic mapped;
  logic osc_on;
  int word;

  // The reset is released through two flops so that no flop leaves reset on a stray edge.
  always_comb
  begin
    next_rst_meta_n = 1'b1;
    next_rst_n = rst_meta_n;
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= next_rst_meta_n;
      rst_n <= next_rst_n;
    end
  end

  assign status = {OSC32_ALT_I, OSC32_EN_I, OSC0_EN_I, TWO_PIN_MODE_I,
                   SINGLE_PIN_DBG_EN_I, TRACE_MAP_SELECT_I, TRACE_EN_I, JTAG_EN_I};

  // Register group: reads are captured in the setup cycle, writes land in the access cycle.
  always_comb
  begin
    setup = PSEL_I && !PENABLE_I;
    word = int'(PADDR_I[7:2]);
    mapped = (PADDR_I[1:0] == 2'h0) && ((PADDR_I < ADDR_FUNC_SEL0 + 8'(4 * SEL_WORDS))
             || (PADDR_I == ADDR_STATUS));
    next_prdata = PRDATA_O;
    next_pslverr = PSLVERR_O;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      next_func_sel[i] = func_sel[i];
    end
    if (setup)
    begin
      next_pslverr = !mapped;
      next_prdata = 32'h00000000;
      if (PADDR_I == ADDR_STATUS)
      begin
        next_prdata = {24'h000000, status};
      end
      else if (mapped)
      begin
        for (int n = 0; n < 8; n++)
        begin
          next_prdata[4*n +: 4] = func_sel[8*word + n];
        end
      end
    end
    // Nibbles of lines that are not bonded out ignore writes, so software reads back which lines exist.
    if (PSEL_I && PENABLE_I && PWRITE_I && mapped && PADDR_I < ADDR_FUNC_SEL0 + 8'(4 * SEL_WORDS))
    begin
      for (int n = 0; n < 8; n++)
      begin
        if (PSTRB_I[n / 2] && (8*word + n < NUM_PADS) && PAD_EXISTS[8*word + n])
        begin
          next_func_sel[8*word + n] = PWDATA_I[4*n +: 4];
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
        func_sel[i] <= FUNC_SEL_RESET[3:0];
      end
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
      PREADY_O <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
        func_sel[i] <= next_func_sel[i];
      end
      PRDATA_O <= next_prdata;
      PSLVERR_O <= next_pslverr;
      PREADY_O <= 1'b1;
    end
  end

  // Pad group: later assignments win, so the code order is the priority order.
  always_comb
  begin
    next_pad.out = GPIO_DRIVE_I.out;
    next_pad.oe = GPIO_DRIVE_I.oe;
    next_twi = '0;
    next_analog = '0;
    osc_on = 1'b0;
    mux_owned = PAD_EXISTS;
    for (int p = 0; p < NUM_PADS; p++)
    begin
      sel = func_sel[p][2:0];
      if (func_sel[p][SEL_EN_BIT])
      begin
        next_pad.out[p] = PERIPH_DRIVE_I[sel].out[p];
        next_pad.oe[p] = PERIPH_DRIVE_I[sel].oe[p];
        next_twi[p] = TWI_FEAT_MASK[p][sel];
      end
    end
    evt_pad = TRACE_MAP_SELECT_I ? EVT_IN_PAD_MAP1 : EVT_IN_PAD_MAP0;
    if (TRACE_EN_I)
    begin
      for (int k = 0; k < 10; k++)
      begin
        tpad = TRACE_MAP_SELECT_I ? TRACE_PAD_MAP1[k] : TRACE_PAD_MAP0[k];
        next_pad.out[tpad] = TRACE_I[k];
        next_pad.oe[tpad] = 1'b1;
        next_twi[tpad] = 1'b0;
        mux_owned[tpad] = 1'b0;
      end
      next_pad.out[evt_pad] = 1'b0;
      next_pad.oe[evt_pad] = 1'b0;
      next_twi[evt_pad] = 1'b0;
      mux_owned[evt_pad] = 1'b0;
    end
    if (SINGLE_PIN_DBG_EN_I && TWO_PIN_MODE_I)
    begin
      next_pad.out[PAD_LINK_DATA_OUT] = DEBUG_LINK_DATA_OUTPUT_I;
      next_pad.oe[PAD_LINK_DATA_OUT] = 1'b1;
      next_twi[PAD_LINK_DATA_OUT] = 1'b0;
      mux_owned[PAD_LINK_DATA_OUT] = 1'b0;
    end
    if (JTAG_EN_I)
    begin
      for (int j = 0; j < 4; j++)
      begin
        next_pad.out[j] = 1'b0;
        next_pad.oe[j] = 1'b0;
        next_twi[j] = 1'b0;
        mux_owned[j] = 1'b0;
      end
      next_pad.out[PAD_JTAG_TDO] = JTAG_TDO_I;
      next_pad.oe[PAD_JTAG_TDO] = 1'b1;
    end
    // Oscillator pads go analog: the digital driver is parked so it cannot load the crystal.
    for (int o = 0; o < 6; o++)
    begin
      unique case (o)
        0: tpad = PAD_XIN0;
        1: tpad = PAD_XOUT0;
        2: tpad = PAD_XIN32;
        3: tpad = PAD_XOUT32;
        4: tpad = PAD_XIN32_ALT;
        default: tpad = PAD_XOUT32_ALT;
      endcase
      // The slow crystal sits on one of two pad pairs, never both, so the alternate select picks one pair.
      unique case (o)
        0, 1: osc_on = OSC0_EN_I;
        2, 3: osc_on = OSC32_EN_I && !OSC32_ALT_I;
        default: osc_on = OSC32_EN_I && OSC32_ALT_I;
      endcase
      if (osc_on)
      begin
        next_pad.out[tpad] = 1'b0;
        next_pad.oe[tpad] = 1'b0;
        next_twi[tpad] = 1'b0;
        next_analog[tpad] = 1'b1;
        mux_owned[tpad] = 1'b0;
      end
    end
    next_pad.out = next_pad.out & PAD_EXISTS;
    next_pad.oe = next_pad.oe & PAD_EXISTS;
    for (int f = 0; f < NUM_FUNCS; f++)
    begin
      for (int p = 0; p < NUM_PADS; p++)
      begin
        next_periph_in[f][p] = mux_owned[p] && func_sel[p][SEL_EN_BIT] &&
                               (func_sel[p][2:0] == 3'(f)) && PAD_IN_I[p];
      end
    end
    next_jtag.tck = JTAG_EN_I && PAD_IN_I[PAD_JTAG_TCK];
    next_jtag.tms = !JTAG_EN_I || PAD_IN_I[PAD_JTAG_TMS];
    next_jtag.tdi = !JTAG_EN_I || PAD_IN_I[PAD_JTAG_TDI];
    next_evt_in_n = !TRACE_EN_I || PAD_IN_I[evt_pad];
    next_dbg_in = SINGLE_PIN_DBG_EN_I && RST_PAD_IN_I;
    next_rst_out = SINGLE_PIN_DBG_EN_I && DBG_DATA_OUT_I;
    next_rst_oe = SINGLE_PIN_DBG_EN_I && DBG_DATA_OE_I;
  end

  // Every pad-facing output is registered, trading one cycle of latency for clean timing.
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PAD_OUT_O <= '0;
      PAD_OE_O <= '0;
      PAD_TWI_FEAT_EN_O <= '0;
      PAD_ANALOG_O <= '0;
      GPIO_IN_O <= '0;
      PERIPH_IN_O <= '0;
      JTAG_IN_O <= 3'h3;
      DEBUG_EVENT_IN_N_O <= 1'b1;
      DBG_DATA_IN_O <= 1'b0;
      RST_PAD_OUT_O <= 1'b0;
      RST_PAD_OE_O <= 1'b0;
      WAKE_N_O <= 1'b1;
    end
    else
    begin
      PAD_OUT_O <= next_pad.out;
      PAD_OE_O <= next_pad.oe;
      PAD_TWI_FEAT_EN_O <= next_twi;
      PAD_ANALOG_O <= next_analog;
      GPIO_IN_O <= PAD_IN_I & PAD_EXISTS;
      PERIPH_IN_O <= next_periph_in;
      JTAG_IN_O <= next_jtag;
      DEBUG_EVENT_IN_N_O <= next_evt_in_n;
      DBG_DATA_IN_O <= next_dbg_in;
      RST_PAD_OUT_O <= next_rst_out;
      RST_PAD_OE_O <= next_rst_oe;
      WAKE_N_O <= PAD_IN_I[PAD_WAKE];
    end
  end

endmodule

//--- pfm_pad_model.sv
`timescale 1ns/1ps
module pfm_pad_model
  import pfm_pkg::*;
(
  input wire logic [NUM_PADS-1:0] out_i,
  input wire logic [NUM_PADS-1:0] oe_i,
  input wire logic [NUM_PADS-1:0] ext_i,
  output logic [NUM_PADS-1:0] lvl_o
);
  // A driven pad reads back its own level, an idle one the board level.
  assign lvl_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

//--- pfm_pad_mux_asserts.sv
`timescale 1ns/1ps
module pfm_pad_mux_chk
  import pfm_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic PREADY_O,
  input wire logic [NUM_PADS-1:0] PAD_IN_I,
  input wire logic [NUM_PADS-1:0] PAD_OUT_O,
  input wire logic [NUM_PADS-1:0] PAD_OE_O,
  input wire logic [NUM_PADS-1:0] PAD_TWI_FEAT_EN_O,
  input wire logic [NUM_PADS-1:0] PAD_ANALOG_O,
  input wire logic JTAG_EN_I,
  input wire logic JTAG_TDO_I,
  input wire pfm_jtag_in_s JTAG_IN_O,
  input wire logic TRACE_EN_I,
  input wire logic TRACE_MAP_SELECT_I,
  input wire pfm_trace_s TRACE_I,
  input wire logic SINGLE_PIN_DBG_EN_I,
  input wire logic TWO_PIN_MODE_I,
  input wire logic DEBUG_LINK_DATA_OUTPUT_I,
  input wire logic OSC0_EN_I,
  input wire logic WAKE_N_O
);
  logic run;
  logic next_run;
  // Checks start a cycle after ready so no look-back reaches into reset.
  always_comb next_run = PREADY_O;
  always_ff @(posedge SYS_CLK_I) run <= next_run;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I || !run);
  tdo_pad_a: assert property (JTAG_EN_I |=> PAD_OE_O[2] && PAD_OUT_O[2] == $past(JTAG_TDO_I))
    else $error("tdo pad wrong");
  scan_in_a: assert property (JTAG_EN_I |=> JTAG_IN_O == {$past(PAD_IN_I[0]), $past(PAD_IN_I[1]), $past(PAD_IN_I[3])})
    else $error("scan inputs wrong");
  osc_pads_a: assert property (OSC0_EN_I |=> PAD_ANALOG_O[9:8] == 2'h3 && PAD_OE_O[9:8] == 2'h0)
    else $error("oscillator pads wrong");
  wake_input_a: assert property (1'b1 |=> WAKE_N_O == $past(PAD_IN_I[11]))
    else $error("wake input wrong");
  link_out_a: assert property (SINGLE_PIN_DBG_EN_I && TWO_PIN_MODE_I && !JTAG_EN_I |=> PAD_OE_O[0] && PAD_OUT_O[0] == $past(DEBUG_LINK_DATA_OUTPUT_I))
    else $error("link output wrong");
  event_out_a: assert property (TRACE_EN_I |=> PAD_OE_O[4] && PAD_OUT_O[4] == $past(TRACE_I.debug_event_out_n))
    else $error("event out wrong");
  frame_map_a: assert property (TRACE_EN_I && TRACE_MAP_SELECT_I |=> PAD_OUT_O[11] == $past(TRACE_I.trace_frame_control[0]))
    else $error("frame pad wrong");
  twi_gate_a: assert property (TRACE_EN_I && TRACE_MAP_SELECT_I |=> !PAD_TWI_FEAT_EN_O[17])
    else $error("twi feature wrong");
  cover property (JTAG_EN_I && TRACE_EN_I);
  cover property (OSC0_EN_I && TRACE_MAP_SELECT_I);
  cover property (SINGLE_PIN_DBG_EN_I && TWO_PIN_MODE_I);
endmodule
bind pfm_pad_mux pfm_pad_mux_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .PREADY_O(PREADY_O),
  .PAD_IN_I(PAD_IN_I), .PAD_OUT_O(PAD_OUT_O), .PAD_OE_O(PAD_OE_O), .PAD_TWI_FEAT_EN_O(PAD_TWI_FEAT_EN_O),
  .PAD_ANALOG_O(PAD_ANALOG_O), .JTAG_EN_I(JTAG_EN_I), .JTAG_TDO_I(JTAG_TDO_I), .JTAG_IN_O(JTAG_IN_O),
  .TRACE_EN_I(TRACE_EN_I), .TRACE_MAP_SELECT_I(TRACE_MAP_SELECT_I), .TRACE_I(TRACE_I),
  .SINGLE_PIN_DBG_EN_I(SINGLE_PIN_DBG_EN_I), .TWO_PIN_MODE_I(TWO_PIN_MODE_I),
  .DEBUG_LINK_DATA_OUTPUT_I(DEBUG_LINK_DATA_OUTPUT_I), .OSC0_EN_I(OSC0_EN_I), .WAKE_N_O(WAKE_N_O));

//--- pfm_pad_mux_tb.sv
`timescale 1ns/1ps
module pfm_pad_mux_tb;
  import pfm_pkg::*;
  logic clk, rst_n, psel, pen, pwr, jen, tdo, ten, tmap, spd, two, ldo, ddo, ddoe, rpi, o0, o32, o32a;
  logic pready, perr, dbi, rpo, rpoe, evi, wake;
  logic [7:0] pa;
  logic [3:0] pstrb;
  logic [31:0] pwd, prd;
  logic [NUM_PADS-1:0] ext, pin, pout, poe, feat, ana, gin;
  logic [NUM_FUNCS-1:0][NUM_PADS-1:0] pfin;
  pfm_drive_s gdrv;
  pfm_drive_s [NUM_FUNCS-1:0] pdrv, drv;
  pfm_trace_s tr;
  pfm_jtag_in_s jin;
  int n_mismatch, n_checks, cyc;
  pfm_pad_mux uut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(pstrb), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
    .GPIO_DRIVE_I(gdrv), .GPIO_IN_O(gin), .PERIPH_DRIVE_I(pdrv), .PERIPH_IN_O(pfin), .PAD_IN_I(pin),
    .PAD_OUT_O(pout), .PAD_OE_O(poe), .PAD_TWI_FEAT_EN_O(feat), .PAD_ANALOG_O(ana), .JTAG_EN_I(jen),
    .JTAG_TDO_I(tdo), .JTAG_IN_O(jin), .TRACE_EN_I(ten), .TRACE_MAP_SELECT_I(tmap), .TRACE_I(tr),
    .DEBUG_EVENT_IN_N_O(evi), .SINGLE_PIN_DBG_EN_I(spd), .TWO_PIN_MODE_I(two), .DEBUG_LINK_DATA_OUTPUT_I(ldo),
    .DBG_DATA_OUT_I(ddo), .DBG_DATA_OE_I(ddoe), .DBG_DATA_IN_O(dbi), .RST_PAD_IN_I(rpi), .RST_PAD_OUT_O(rpo),
    .RST_PAD_OE_O(rpoe), .OSC0_EN_I(o0), .OSC32_EN_I(o32), .OSC32_ALT_I(o32a), .WAKE_N_O(wake));
  pfm_pad_model pads (.out_i(pout), .oe_i(poe), .ext_i(ext), .lvl_o(pin));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      results();
    end
  end
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [44:0] e, input logic [44:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A read compares against d; the extra idle edge keeps psel from being set twice in one step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n = n + 1;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      $display("mismatch pready expected 1 seen %b", pready);
      results();
    end
    chk("pslverr", ee, perr);
    if (!w) chk("prdata", d, prd);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  initial
  begin
    {psel, pen, pwr, jen, tdo, ten, tmap, spd, two, ldo, ddo, ddoe, rpi, o0, o32, o32a} = '0;
    pa = '0;
    pwd = '0;
    pstrb = '1;
    ext = '1;
    gdrv = '0;
    pdrv = '0;
    tr = '0;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    tk(20);
    rst_n <= 1'b1;
    tk(4);
    bus(1'b0, 8'h00, 32'h0, 1'b0);
    chk("idle inputs", 45'h7, {jin, evi});
    for (int f = 0; f < NUM_FUNCS; f++)
    begin
      drv = '0;
      drv[f] = '{out: '1, oe: '1};
      pdrv <= drv;
      bus(1'b1, 8'h00, {24'h0, 4'h8 | 4'(f), 4'h0}, 1'b0);
      tk(2);
      chk("line1 drive", 45'h3, {pout[1], poe[1]});
      chk("line1 in", 45'h2, pfin[f] & 45'h2);
    end
    gdrv <= '{out: '1, oe: '1};
    pdrv <= '0;
    bus(1'b1, 8'h00, 32'h0, 1'b0);
    tk(1);
    chk("gpio line1", 45'h3, {pout[1], poe[1]});
    gdrv <= '0;
    bus(1'b1, 8'h08, 32'hFEDCBAB8, 1'b0);
    bus(1'b0, 8'h08, 32'h0EDCBAB8, 1'b0);
    pstrb <= 4'h8;
    bus(1'b1, 8'h08, 32'h0, 1'b0);
    pstrb <= 4'hF;
    bus(1'b0, 8'h08, 32'h00DCBAB8, 1'b0);
    chk("twi line17", 45'h1, feat[17]);
    bus(1'b1, 8'h24, 32'hFFFFFFFF, 1'b1);
    bus(1'b0, 8'h02, 32'h0, 1'b1);
    drv = '0;
    drv[0] = '{out: '1, oe: '1};
    pdrv <= drv;
    bus(1'b1, 8'h00, 32'h8, 1'b0);
    {spd, two, ddo, ddoe, rpi} <= 5'h1F;
    tk(2);
    chk("link over mux", 45'h1, {pout[0], poe[0]});
    chk("reset pad on", 45'h7, {rpo, rpoe, dbi});
    {jen, tdo} <= 2'h3;
    tk(2);
    chk("scan over link", 45'h3, {poe[0], pout[2], poe[2]});
    {ten, tmap, o0, o32} <= 4'hF;
    tr <= '1;
    tk(2);
    bus(1'b0, 8'h20, 32'h7F, 1'b0);
    chk("osc over trace", 45'h2, {ana[10], poe[10]});
    chk("trace frame", 45'h3, {pout[11], poe[11]});
    chk("twi under trace", 45'h0, feat[17]);
    {tmap, o32a} <= 2'h1;
    ext[40] <= 1'b0;
    tk(2);
    chk("trace map", 45'h2, {pout[44], pout[11]});
    chk("event in", 45'h0, evi);
    chk("osc alt", 45'h6, {ana[20], ana[13], ana[10]});
    {spd, ten, jen, o0, o32} <= 5'h0;
    ext[11] <= 1'b0;
    tk(2);
    chk("reset pad off", 45'h0, {rpo, rpoe, dbi, wake});
    chk("gpio in", ext & PAD_EXISTS, gin);
    for (int f = 0; f < NUM_FUNCS; f++)
    begin
      bus(1'b1, 8'h00, 32'h00800000 | (32'(f) << 20), 1'b0);
      tk(1);
      chk("twi feature", 45'(TWI_FEAT_MASK[5][f]), feat[5]);
    end
    results();
  end
endmodule
